/* File: odtt_pkg.sv */
// Summary of operation
// - Sync turn-on after write latency minus two
// - Sync turn-off after write latency minus two
// - Turn-on completes within skew after latency
// - Turn-off completes half cycle after latency
// - Async control in DLL-off powerdown, resync
// - Async mode ignores additive latency
// - Async termination fully on within 8.5ns; the code takes one 25ns cycle
// - Async termination fully off within 8.5ns; the code takes one 25ns cycle
// - Entry period leads first registered CKE low; the code starts it at that CKE low edge, and only while a refresh runs
// - Refresh in flight extends entry period
// - Entry period may behave sync or async
// - Entry turn-on between async and sync bounds
// - Entry turn-off between async and sync bounds
// - Sync mode when DLL locked, termination on
package odtt_pkg;

  // Command clock period
  localparam int CLK_PERIOD_PS      = 25000;
  // Longest asynchronous turn-on and turn-off times
  localparam int ASYNC_ON_DELAY_PS  = 8500;
  localparam int ASYNC_OFF_DELAY_PS = 8500;
  // Longest times round down, but never below one cycle
  localparam int ASYNC_ON_CYC  = (ASYNC_ON_DELAY_PS / CLK_PERIOD_PS < 1) ?
                                 1 : ASYNC_ON_DELAY_PS / CLK_PERIOD_PS;
  localparam int ASYNC_OFF_CYC = (ASYNC_OFF_DELAY_PS / CLK_PERIOD_PS < 1) ?
                                 1 : ASYNC_OFF_DELAY_PS / CLK_PERIOD_PS;
  // Latency is write latency less this offset
  localparam int ODT_LAT_OFFSET = 2;
  // Entry lead interval is the latency plus this many cycles
  localparam int LEAD_EXTRA_CYC = 1;
  // Minimum high windows of the ODT pin
  localparam int HOLD_SHORT_CYC = 4;
  localparam int HOLD_LONG_CYC  = 6;
  // Widths of latency, history line and counters
  localparam int LAT_W     = 5;
  localparam int HIST_D    = 32;
  localparam int CNT_W     = 8;
  // Reset values
  localparam logic [LAT_W-1:0] LAT_RST  = 5'h03;
  localparam logic [HIST_D-1:0] HIST_RST = 32'h0000_0000;

  // Termination timing model, one-hot
  typedef enum logic [2:0]
  {
    ODTT_MODE_SYNC  = 3'b001,
    ODTT_MODE_ENTRY = 3'b010,
    ODTT_MODE_ASYNC = 3'b100
  } odtt_mode_t;

  // DLL is not locked out of reset, so start asynchronous
  localparam odtt_mode_t MODE_RST = ODTT_MODE_ASYNC;

endpackage : odtt_pkg

/* File: odtt_down_cnt.sv */
`timescale 1ns/1ps
// Down counter whose load only ever raises the count, so two
// overlapping windows end at the later of the two, except that a new length equal to the count left is not loaded
module odtt_down_cnt #(
  parameter int W = 8                // Counter width
) (
  input  wire logic         clk_sys,  // Command clock
  input  wire logic         arst_n,   // Async reset, active low
  input  wire logic         load,     // Request a new window
  input  wire logic [W-1:0] load_val, // Window length in cycles
  output logic      [W-1:0] count,    // Cycles left
  output logic              busy      // Window still open
);

  logic [W-1:0] cnt_reg;   // Current count
  logic [W-1:0] cnt_next;  // Next count

  // Raise to the new window, otherwise count down to zero
  always_comb
  begin
    cnt_next = cnt_reg;
    if (load && (load_val > cnt_reg))
    begin
      cnt_next = load_val;
    end
    else if (cnt_reg != '0)
    begin
      cnt_next = cnt_reg - W'(1);
    end
  end

  // Counter register
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_reg <= '0;
    end
    else
    begin
      cnt_reg <= cnt_next;
    end
  end

  assign count = cnt_reg;
  assign busy  = (cnt_reg != '0);

endmodule : odtt_down_cnt

/* File: odtt_ctrl.sv */
`timescale 1ns/1ps
// Termination control: picks the timing model, delays the ODT
// pin by the right amount and watches the controller's holds.
module odtt_ctrl #(
  parameter int REFRESH_CYCLE_PS = 160000  // Refresh cycle time
) (
  input  wire logic       clk_sys,         // Command clock
  input  wire logic       arst_n,          // Async reset, active low
  input  wire logic       odt_pin,         // ODT level from controller
  input  wire logic       cke_pin,         // Clock enable level
  input  wire logic       cmd_write,       // WRITE registered, pulse
  input  wire logic       cmd_refresh,     // REFRESH registered, pulse
  input  wire logic       write_chop,      // This WRITE is a chop of 4
  input  wire logic       banks_idle,      // All banks precharged
  input  wire logic       dll_locked,      // DLL on and locked
  input  wire logic       pd_dll_keep,     // DLL stays on in powerdown
  input  wire logic       nom_term_en,     // Nominal termination set
  input  wire logic       wr_term_en,      // Write termination set
  input  wire logic [3:0] cwl,             // CAS write latency
  input  wire logic [3:0] al,              // Additive latency
  output logic            term_en,         // Termination applied
  output logic            term_sync_mode,  // Sync timing in force
  output logic            term_async_mode, // Async timing in force
  output logic            pd_entry_active, // Entry held by refresh
  output logic            odt_hold_busy,   // ODT must stay high
  output logic            odt_hold_err     // ODT dropped too early
);

  // Refresh cycle time as whole cycles, rounded up
  localparam int RFC_CYC = (REFRESH_CYCLE_PS + odtt_pkg::CLK_PERIOD_PS
                           - 1) / odtt_pkg::CLK_PERIOD_PS;
  localparam int RFC_WAIT = RFC_CYC + 2;  // Bound used when checking

  // Configuration and pipeline state
  logic [odtt_pkg::LAT_W-1:0]  lat_reg;      // Sync latency in cycles
  logic [odtt_pkg::LAT_W-1:0]  lat_next;     // Next latency
  logic [odtt_pkg::HIST_D-1:0] hist_reg;     // Past ODT samples
  logic [odtt_pkg::HIST_D-1:0] hist_next;    // Next history
  logic                        term_reg;     // Termination state
  logic                        term_next;    // Next termination state
  logic                        odt_d_reg;    // ODT of previous cycle
  logic                        err_reg;      // Early drop seen
  logic                        err_next;     // Next early drop flag
  odtt_pkg::odtt_mode_t        mode_reg;     // Timing model
  odtt_pkg::odtt_mode_t        mode_next;    // Next timing model

  // Helper terms
  logic                        term_any;     // Any termination set
  logic                        ppd_dll_off;  // Precharge pd, DLL off
  logic                        odt_rise;     // ODT registered high now
  logic                        hold_load;    // A hold window starts
  logic [odtt_pkg::CNT_W-1:0]  hold_val;     // Its length less one
  logic                        refresh_busy; // Refresh still running
  logic [5:0]                  wl_sum;       // Write latency sum

  assign term_any    = nom_term_en | wr_term_en;
  assign ppd_dll_off = !cke_pin && banks_idle && !pd_dll_keep;
  assign odt_rise    = odt_pin && !odt_d_reg;
  assign wl_sum      = {2'h0, cwl} + {2'h0, al};

  // Hold windows: a new ODT assertion opens the short one, a
  // WRITE with ODT high opens short or long by its burst size;
  // the counter keeps the larger of the new length and the count left.
  always_comb
  begin
    hold_load = 1'b0;
    hold_val  = '0;
    if (cmd_write && odt_pin)
    begin
      hold_load = 1'b1;
      hold_val  = write_chop
                ? odtt_pkg::CNT_W'(odtt_pkg::HOLD_SHORT_CYC - 1)
                : odtt_pkg::CNT_W'(odtt_pkg::HOLD_LONG_CYC - 1);
    end
    else if (odt_rise)
    begin
      hold_load = 1'b1;
      hold_val  = odtt_pkg::CNT_W'(odtt_pkg::HOLD_SHORT_CYC - 1);
    end
  end

  // Larger of the new length and the count left wins
  odtt_down_cnt #(
    .W        (odtt_pkg::CNT_W)
  ) u_hold_cnt (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .load     (hold_load),
    .load_val (hold_val),
    .count    (),
    .busy     (odt_hold_busy)
  );

  // Refresh in progress, for stretching the entry period
  odtt_down_cnt #(
    .W        (odtt_pkg::CNT_W)
  ) u_rfc_cnt (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .load     (cmd_refresh),
    .load_val (odtt_pkg::CNT_W'(RFC_CYC)),
    .count    (),
    .busy     (refresh_busy)
  );

  // Timing model selection
  always_comb
  begin
    case (mode_reg)
      odtt_pkg::ODTT_MODE_SYNC:
      begin
        if (!dll_locked)
          mode_next = odtt_pkg::ODTT_MODE_ASYNC;
        else if (ppd_dll_off && refresh_busy)
          mode_next = odtt_pkg::ODTT_MODE_ENTRY;
        else if (ppd_dll_off)
          mode_next = odtt_pkg::ODTT_MODE_ASYNC;
        else
          mode_next = odtt_pkg::ODTT_MODE_SYNC;
      end
      odtt_pkg::ODTT_MODE_ENTRY:
      begin
        // Stay synchronous until the refresh cycle is over
        if (!dll_locked)
          mode_next = odtt_pkg::ODTT_MODE_ASYNC;
        else if (!ppd_dll_off)
          mode_next = odtt_pkg::ODTT_MODE_SYNC;
        else if (!refresh_busy)
          mode_next = odtt_pkg::ODTT_MODE_ASYNC;
        else
          mode_next = odtt_pkg::ODTT_MODE_ENTRY;
      end
      odtt_pkg::ODTT_MODE_ASYNC:
      begin
        // Locked DLL outside DLL-off powerdown means sync
        if (dll_locked && !ppd_dll_off)
          mode_next = odtt_pkg::ODTT_MODE_SYNC;
        else
          mode_next = odtt_pkg::ODTT_MODE_ASYNC;
      end
      default:
      begin
        mode_next = odtt_pkg::MODE_RST;
      end
    endcase
  end

  // Mode register
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_reg <= odtt_pkg::MODE_RST;
    end
    else
    begin
      mode_reg <= mode_next;
    end
  end

  // Latency, history and termination. The ODT sample taken at
  // one edge sits in history slot k after k more edges, so the
  // slot at latency minus one gives the change at the latency
  // edge. Sub-cycle skew is left to the analog output stage;
  // the edge below is the point the skew is measured from.
  always_comb
  begin
    lat_next = odtt_pkg::LAT_W'(wl_sum - 6'(odtt_pkg::ODT_LAT_OFFSET));
    if (wl_sum <= 6'(odtt_pkg::ODT_LAT_OFFSET))
    begin
      // Too small a latency is held at one cycle
      lat_next = odtt_pkg::LAT_W'(1);
    end
    hist_next = {hist_reg[odtt_pkg::HIST_D-2:0], odt_pin};
    err_next  = odt_hold_busy && !odt_pin && odt_d_reg;
    term_next = 1'b0;
    if (!term_any)
    begin
      // No termination programmed, pin stays high impedance
      term_next = 1'b0;
    end
    else if (mode_reg == odtt_pkg::ODTT_MODE_ASYNC)
    begin
      // Additive latency plays no part here
      if (odt_pin)
        term_next = hist_reg[odtt_pkg::ASYNC_ON_CYC - 1];
      else
        term_next = hist_reg[odtt_pkg::ASYNC_OFF_CYC - 1];
    end
    else
    begin
      // Sync and entry both use the latency path; during entry
      // this meets the mixed bounds at their sync end
      term_next = hist_reg[lat_reg - odtt_pkg::LAT_W'(1)];
    end
  end

  // Registers for latency, history and the termination output
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lat_reg   <= odtt_pkg::LAT_RST;
      hist_reg  <= odtt_pkg::HIST_RST;
      term_reg  <= 1'b0;
      odt_d_reg <= 1'b0;
      err_reg   <= 1'b0;
    end
    else
    begin
      lat_reg   <= lat_next;
      hist_reg  <= hist_next;
      term_reg  <= term_next;
      odt_d_reg <= odt_pin;
      err_reg   <= err_next;
    end
  end

  // Outputs. Entering async drops the changes still waiting in
  // the latency line; the pin then follows within the async
  // delay, which lies inside the mixed entry bounds.
  assign term_en         = term_reg;
  assign term_sync_mode  = (mode_reg != odtt_pkg::ODTT_MODE_ASYNC);
  assign term_async_mode = (mode_reg == odtt_pkg::ODTT_MODE_ASYNC);
  assign pd_entry_active = (mode_reg == odtt_pkg::ODTT_MODE_ENTRY);
  assign odt_hold_err    = err_reg;

  // ODT high is seen at the output after the sync latency
  property p_sync_on;
    @(posedge clk_sys) disable iff (!arst_n)
    (term_any && term_sync_mode && lat_reg == 5'h03 && odt_pin)
    ##1 (term_any && term_sync_mode && lat_reg == 5'h03) [*3]
    |=> term_en;
  endproperty
  a_sync_on: assert property (p_sync_on)
    else $error("sync turn-on latency missed");

  // ODT low is seen at the output after the sync latency
  property p_sync_off;
    @(posedge clk_sys) disable iff (!arst_n)
    (term_sync_mode && lat_reg == 5'h03 && !odt_pin)
    ##1 (term_sync_mode && lat_reg == 5'h03) [*3]
    |=> !term_en;
  endproperty
  a_sync_off: assert property (p_sync_off)
    else $error("sync turn-off latency missed");

  // Termination must not follow ODT early in sync mode
  property p_sync_not_early;
    @(posedge clk_sys) disable iff (!arst_n)
    (term_sync_mode && lat_reg == 5'h03 && !term_en && $rose(odt_pin))
    ##1 term_sync_mode |-> !term_en;
  endproperty
  a_sync_not_early: assert property (p_sync_not_early)
    else $error("termination came on before latency");

  // Async turn-on within one cycle of ODT high
  property p_async_on;
    @(posedge clk_sys) disable iff (!arst_n)
    (term_async_mode && term_any && odt_pin)
    ##1 (term_async_mode && term_any) |=> term_en;
  endproperty
  a_async_on: assert property (p_async_on)
    else $error("async turn-on too slow");

  // Async turn-off within one cycle of ODT low
  property p_async_off;
    @(posedge clk_sys) disable iff (!arst_n)
    (term_async_mode && !odt_pin) ##1 term_async_mode |=> !term_en;
  endproperty
  a_async_off: assert property (p_async_off)
    else $error("async turn-off too slow");

  // Loss of DLL lock forces async timing
  property p_dll_unlock;
    @(posedge clk_sys) disable iff (!arst_n)
    !dll_locked |=> term_async_mode;
  endproperty
  a_dll_unlock: assert property (p_dll_unlock)
    else $error("async mode not taken");

  // Locked DLL outside DLL-off powerdown gives sync timing
  property p_sync_sel;
    @(posedge clk_sys) disable iff (!arst_n)
    (dll_locked && !ppd_dll_off) |=> term_sync_mode && !pd_entry_active;
  endproperty
  a_sync_sel: assert property (p_sync_sel)
    else $error("sync mode not taken");

  // Entry held by a refresh ends within the refresh time plus two cycles
  property p_entry_end;
    @(posedge clk_sys) disable iff (!arst_n)
    $rose(pd_entry_active) |-> ##[1:RFC_WAIT] !pd_entry_active;
  endproperty
  a_entry_end: assert property (p_entry_end)
    else $error("entry period did not end");

  // CKE low in DLL-off powerdown without refresh goes async
  property p_entry_plain;
    @(posedge clk_sys) disable iff (!arst_n)
    (dll_locked && ppd_dll_off && !refresh_busy && !pd_entry_active)
    |=> term_async_mode;
  endproperty
  a_entry_plain: assert property (p_entry_plain)
    else $error("entry did not end at CKE low");

  // New ODT assertion opens a four-cycle window
  property p_hold_short;
    @(posedge clk_sys) disable iff (!arst_n)
    odt_rise |=> odt_hold_busy [*3];
  endproperty
  a_hold_short: assert property (p_hold_short)
    else $error("short hold window too short");

  // Without a WRITE the short window closes after four cycles
  property p_hold_close;
    @(posedge clk_sys) disable iff (!arst_n)
    (odt_rise && !cmd_write) ##1 (!cmd_write && !odt_rise) [*3]
    |=> !odt_hold_busy;
  endproperty
  a_hold_close: assert property (p_hold_close)
    else $error("short hold window too long");

  // Full-burst WRITE with ODT high opens a six-cycle window
  property p_hold_long;
    @(posedge clk_sys) disable iff (!arst_n)
    (cmd_write && odt_pin && !write_chop) |=> odt_hold_busy [*5];
  endproperty
  a_hold_long: assert property (p_hold_long)
    else $error("long hold window too short");

endmodule : odtt_ctrl

/* File: odtt_ctl_model.sv */
`timescale 1ns/1ps
// Memory-controller model: drives ODT, CKE and commands just after
// the rising edge and keeps ODT high for the hold that the device needs
module odtt_ctl_model (
  input  wire logic clk_sys,     // Command clock
  output logic      odt_pin,     // ODT level to the device
  output logic      cke_pin,     // Clock enable level
  output logic      cmd_write,   // WRITE pulse
  output logic      cmd_refresh, // REFRESH pulse
  output logic      write_chop   // Chop of four for this WRITE
);
  // Idle controller at time zero: CKE high, no command, ODT low
  initial
  begin
    odt_pin     = 1'h0;
    cke_pin     = 1'h1;
    cmd_write   = 1'h0;
    cmd_refresh = 1'h0;
    write_chop  = 1'h0;
  end

  // ODT burst, optional WRITE wdly cycles in; the length is the
  // legal minimum plus extra, so a slow controller passes extra > 0
  // and only a negative extra breaks the hold on purpose
  task automatic burst(input logic wr, input int wdly,
                       input logic chop, input int extra);
    int len;
    int whold;
    len = odtt_pkg::HOLD_SHORT_CYC;
    whold = chop ? odtt_pkg::HOLD_SHORT_CYC
                 : odtt_pkg::HOLD_LONG_CYC;
    if (wr && (wdly + whold > len))
      len = wdly + whold;
    len = len + extra;
    @(posedge clk_sys);
    odt_pin <= 1'h1;
    for (int i = 0; i < len; i++)
    begin
      cmd_write  <= wr && (i == wdly);
      write_chop <= chop;
      @(posedge clk_sys);
    end
    // No READ is ever issued and ODT ends low, so reads never
    // meet termination
    odt_pin   <= 1'h0;
    cmd_write <= 1'h0;
  endtask : burst

  // One-cycle REFRESH command
  task automatic refresh;
    @(posedge clk_sys);
    cmd_refresh <= 1'h1;
    @(posedge clk_sys);
    cmd_refresh <= 1'h0;
  endtask : refresh

  // New CKE level from the next edge on
  task automatic set_cke(input logic lvl);
    @(posedge clk_sys);
    cke_pin <= lvl;
  endtask : set_cke
endmodule : odtt_ctl_model

/* File: tb_odtt_ctrl.sv */
`timescale 1ns/1ps
// Self-checking bench for the termination control
module tb_odtt_ctrl;
  localparam int REF_PS = 160000;                  // Refresh cycle time
  localparam int RFC = (REF_PS + 24999) / 25000;   // Refresh in cycles
  logic       clk_sys;         // Command clock
  logic       arst_n;          // Reset, active low
  logic       odt_pin;         // From controller model
  logic       cke_pin;         // From controller model
  logic       cmd_write;       // From controller model
  logic       cmd_refresh;     // From controller model
  logic       write_chop;      // From controller model
  logic       banks_idle;      // All banks precharged
  logic       dll_locked;      // DLL locked
  logic       pd_dll_keep;     // DLL kept on in powerdown
  logic       nom_term_en;     // Nominal termination set
  logic       wr_term_en;      // Write termination set
  logic [3:0] cwl;             // CAS write latency
  logic [3:0] al;              // Additive latency
  logic       term_en;         // Termination applied
  logic       term_sync_mode;  // Sync timing
  logic       term_async_mode; // Async timing
  logic       pd_entry_active; // Entry stretched by refresh
  logic       odt_hold_busy;   // Hold window open
  logic       odt_hold_err;    // Early ODT drop
  int         num_errors;      // Mismatches
  int         num_checks;      // Comparisons
  int         err_seen;        // Hold error pulses seen

  // Free-running 40 MHz clock
  initial
  begin
    clk_sys = 1'h0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  odtt_ctrl #(.REFRESH_CYCLE_PS(REF_PS)) u_odtt_ctrl (
    .clk_sys(clk_sys), .arst_n(arst_n), .odt_pin(odt_pin),
    .cke_pin(cke_pin), .cmd_write(cmd_write), .cmd_refresh(cmd_refresh),
    .write_chop(write_chop), .banks_idle(banks_idle),
    .dll_locked(dll_locked), .pd_dll_keep(pd_dll_keep),
    .nom_term_en(nom_term_en), .wr_term_en(wr_term_en), .cwl(cwl),
    .al(al), .term_en(term_en), .term_sync_mode(term_sync_mode),
    .term_async_mode(term_async_mode), .pd_entry_active(pd_entry_active),
    .odt_hold_busy(odt_hold_busy), .odt_hold_err(odt_hold_err));

  odtt_ctl_model u_odtt_ctl_model (
    .clk_sys(clk_sys), .odt_pin(odt_pin), .cke_pin(cke_pin),
    .cmd_write(cmd_write), .cmd_refresh(cmd_refresh),
    .write_chop(write_chop));

  // Error pulse stands one cycle, so count it at every edge
  always @(posedge clk_sys)
    if (odt_hold_err === 1'h1)
      err_seen++;

  // Compare one bit, four-state
  task automatic check(input string what, input logic seen,
                       input logic exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  // Verdict and end of run
  task automatic finish_test;
    $display("checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  // Reset for 8 cycles with a new latency setting, which only loads
  // at the first edge after release
  task automatic do_reset(input logic [3:0] c, input logic [3:0] a);
    u_odtt_ctl_model.set_cke(1'h1);
    arst_n      <= 1'h0;
    cwl         <= c;
    al          <= a;
    dll_locked  <= 1'h1;
    pd_dll_keep <= 1'h1;
    banks_idle  <= 1'h1;
    nom_term_en <= 1'h1;
    wr_term_en  <= 1'h1;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'h1;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : do_reset

  // Follows one burst of hi cycles through a latency of lat edges
  task automatic lat_check(input int lat, input int hi);
    @(posedge clk_sys);
    repeat (lat) @(posedge clk_sys);
    #1 check("term on early", term_en, 1'h0);
    @(posedge clk_sys);
    #1 check("term on", term_en, 1'h1);
    repeat (hi - 1) @(posedge clk_sys);
    #1 check("term off early", term_en, 1'h1);
    @(posedge clk_sys);
    #1 check("term off", term_en, 1'h0);
  endtask : lat_check

  // Sync latency is write latency less two, additive latency included
  task automatic t_sync_lat(input logic [3:0] c, input logic [3:0] a);
    int lat;
    // Too small a write latency still leaves one cycle of latency
    lat = int'(c) + int'(a) - odtt_pkg::ODT_LAT_OFFSET;
    if (lat < 1)
      lat = 1;
    do_reset(c, a);
    check("sync mode", term_sync_mode, 1'h1);
    fork
      u_odtt_ctl_model.burst(1'h0, 0, 1'h0, 4);
      lat_check(lat, 8);
    join
  endtask : t_sync_lat

  // Without DLL lock the additive latency must not delay ODT
  task automatic t_async;
    do_reset(4'h5, 4'h3);
    @(posedge clk_sys);
    dll_locked <= 1'h0;
    repeat (2) @(posedge clk_sys);
    #1 check("async mode", term_async_mode, 1'h1);
    check("sync mode off", term_sync_mode, 1'h0);
    fork
      u_odtt_ctl_model.burst(1'h0, 0, 1'h0, 4);
      lat_check(1, 8);
    join
  endtask : t_async

  // No termination programmed forces termination off mid-burst
  task automatic t_term_off;
    do_reset(4'h5, 4'h0);
    fork
      u_odtt_ctl_model.burst(1'h0, 0, 1'h0, 16);
      begin
        repeat (6) @(posedge clk_sys);
        #1 check("term mid burst", term_en, 1'h1);
        @(posedge clk_sys);
        nom_term_en <= 1'h0;
        wr_term_en  <= 1'h0;
        @(posedge clk_sys);
        #1 check("term unprogrammed", term_en, 1'h0);
      end
    join
    @(posedge clk_sys);
    nom_term_en <= 1'h1;
    wr_term_en  <= 1'h1;
  endtask : t_term_off

  // Hold windows: each row is wr, wdly, chop, extra, error expected
  task automatic t_hold;
    int tbl [8][5] = '{'{0, 0, 0, 0, 0}, '{0, 0, 0, -1, 1},
                       '{1, 0, 1, 0, 0}, '{1, 0, 1, -1, 1},
                       '{1, 0, 0, 0, 0}, '{1, 0, 0, -1, 1},
                       '{1, 2, 1, 0, 0}, '{1, 2, 1, -1, 1}};
    logic err_exp;
    for (int i = 0; i < 8; i++)
    begin
      err_seen = 0;
      err_exp  = tbl[i][4][0];
      u_odtt_ctl_model.burst(tbl[i][0][0], tbl[i][1], tbl[i][2][0],
                             tbl[i][3]);
      repeat (4) @(posedge clk_sys);
      #1 check("hold error", err_seen != 0, err_exp);
      check("hold busy idle", odt_hold_busy, 1'h0);
    end
  endtask : t_hold

  // Power-down with DLL kept stays sync; DLL off turns async
  task automatic t_entry_plain;
    u_odtt_ctl_model.set_cke(1'h0);
    @(posedge clk_sys);
    #1 check("pd dll kept", term_sync_mode, 1'h1);
    @(posedge clk_sys);
    pd_dll_keep <= 1'h0;
    banks_idle  <= 1'h0;
    @(posedge clk_sys);
    #1 check("active pd", term_sync_mode, 1'h1);
    @(posedge clk_sys);
    banks_idle  <= 1'h1;
    @(posedge clk_sys);
    #1 check("pd dll off", term_async_mode, 1'h1);
    u_odtt_ctl_model.set_cke(1'h1);
    @(posedge clk_sys);
    #1 check("pd exit sync", term_sync_mode, 1'h1);
  endtask : t_entry_plain

  // Refresh in flight stretches the entry period to the refresh time
  task automatic t_entry_refresh;
    do_reset(4'h5, 4'h0);
    @(posedge clk_sys);
    pd_dll_keep <= 1'h0;
    u_odtt_ctl_model.refresh();
    u_odtt_ctl_model.set_cke(1'h0);
    @(posedge clk_sys);
    #1 check("entry held", pd_entry_active, 1'h1);
    check("entry timing", term_sync_mode, 1'h1);
    repeat (RFC - 2) @(posedge clk_sys);
    #1 check("entry still held", pd_entry_active, 1'h1);
    @(posedge clk_sys);
    #1 check("entry ended", pd_entry_active, 1'h0);
    check("async after entry", term_async_mode, 1'h1);
  endtask : t_entry_refresh

  // Main sequence
  initial
  begin
    num_errors  = 0;
    num_checks  = 0;
    err_seen    = 0;
    arst_n      = 1'h0;
    banks_idle  = 1'h1;
    dll_locked  = 1'h1;
    pd_dll_keep = 1'h1;
    nom_term_en = 1'h1;
    wr_term_en  = 1'h1;
    cwl         = 4'h5;
    al          = 4'h0;
    t_sync_lat(4'h5, 4'h0);
    t_sync_lat(4'h5, 4'h3);
    t_sync_lat(4'h8, 4'h6);
    t_sync_lat(4'h2, 4'h0);
    t_async;
    t_term_off;
    t_hold;
    t_entry_plain;
    t_entry_refresh;
    finish_test;
  end

  // Watchdog: the tests need well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    finish_test;
  end
endmodule : tb_odtt_ctrl
